/* File: rtl/bus_dominance_timer.sv */
// Saturating cycle timer that expires after a run of LIMIT cycles
module bus_dominance_timer
#(
    parameter logic [31:0] LIMIT = 32'h1
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    output logic expired
);

    logic [31:0] count; // Cycles spent with run high

    // Restart on every drop of run; hold at the limit so it never wraps
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            count <= 32'h0;
        else if (!run)
            count <= 32'h0;
        else if (count != LIMIT)
            count <= count + 32'h1;
    end

    // Only meaningful while the condition still holds
    assign expired = run && (count == LIMIT);

endmodule

/* File: rtl/bus_transceiver_wake_supervision.sv */
// Mode supervision of the high-speed bus transceiver: wake, termination, time-outs, supply
`include "bus_trx_consts.svh"

module bus_transceiver_wake_supervision
    import bus_trx_pkg::*;
#(
    parameter logic [31:0] TRANSMIT_DOMINANT_TIMEOUT_CYCLES = `TRANSMIT_DOMINANT_TIMEOUT_CYCLES_DEF,
    parameter logic [31:0] BUS_CLAMP_TIMEOUT_CYCLES = `BUS_CLAMP_TIMEOUT_CYCLES_DEF,
    parameter logic [31:0] SILENCE_TIME_CYCLES = `SILENCE_TIME_CYCLES_DEF
)
(
    input wire logic REF_CLK,
    input wire logic RESET_N,
    input wire logic [2:0] DEVICE_MODE,
    input wire logic [1:0] TRX_MODE,
    input wire logic WATCHDOG_ENABLED,
    input wire logic WATCHDOG_ON_BUS_WAKE,
    input wire logic BUS_WAKE_DETECT,
    input wire logic BUS_TRANSMIT_IN,
    input wire logic BUS_RX_RAW,
    input wire logic SUPPLY_UV_IN,
    input wire logic WAKE_STATUS_CLEAR,
    input wire logic FAULT_CLEAR,
    input wire logic SUPPLY_LOW_CLEAR,
    input wire logic EVENT_READY,
    output logic IRQ_OUT_N,
    output logic BUS_RECEIVE_OUT,
    output logic DRIVER_TX,
    output logic DRIVER_ENABLE,
    output logic [1:0] TERM_SEL,
    output logic WAKE_SOURCE_STATUS,
    output logic FAULT_FLAG,
    output logic TRANSCEIVER_SUPPLY_LOW_FLAG,
    output logic MODE_RESTART_REQ,
    output logic WATCHDOG_AUTO_ENABLE,
    output logic EVENT_VALID,
    output logic [3:0] EVENT_DATA
);

    // Index of each timer in the generated bank
    localparam int TMR_TX = 0;
    localparam int TMR_CLAMP = 1;
    localparam int TMR_SILENCE = 2;
    localparam int TMR_COUNT = 3;

    // Clamp limit is pushed past the transmit limit if a bench shortens them badly
    localparam logic [31:0] CLAMP_LIMIT =
        (BUS_CLAMP_TIMEOUT_CYCLES > TRANSMIT_DOMINANT_TIMEOUT_CYCLES) ?
        BUS_CLAMP_TIMEOUT_CYCLES : (TRANSMIT_DOMINANT_TIMEOUT_CYCLES + 32'h1);

    // Limits of the timer bank, all overridable counts
    localparam logic [31:0] TIMER_LIMIT [TMR_COUNT] =
        '{TRANSMIT_DOMINANT_TIMEOUT_CYCLES, CLAMP_LIMIT, SILENCE_TIME_CYCLES};

    // Decoded modes
    device_mode_e dev_mode; // Current device mode
    trx_mode_e trx_mode; // Current transceiver mode
    device_mode_e prev_dev; // Device mode one cycle ago
    trx_mode_e prev_trx; // Transceiver mode one cycle ago

    assign dev_mode = device_mode_e'(DEVICE_MODE);
    assign trx_mode = trx_mode_e'(TRX_MODE);

    wire trx_normal = (trx_mode == TRX_NORMAL);
    wire trx_rxonly = (trx_mode == TRX_RXONLY);
    wire trx_wake = (trx_mode == TRX_WAKE);
    // Upper mode bit alone gates the supply monitor
    wire monitor_en = TRX_MODE[1];
    wire dev_awake = (dev_mode == DEV_NORMAL) || (dev_mode == DEV_STOP);
    wire dev_low_power = (dev_mode == DEV_SLEEP) || (dev_mode == DEV_RESTART) ||
        (dev_mode == DEV_FAILSAFE);
    wire dev_rearm_mode = (dev_mode == DEV_STOP) || (dev_mode == DEV_SLEEP) ||
        (dev_mode == DEV_FAILSAFE);

    // State registers
    logic woken; // Wake seen, capability disarmed
    logic tx_blocked; // Transmitter held recessive after time-out
    logic clamp_seen; // Clamp already reported for this dominant run
    logic uv_seen; // Undervoltage already reported
    event_s pending; // Events waiting for buffer space

    // Timer bank outputs
    logic [TMR_COUNT-1:0] timer_run; // Condition under measurement
    logic [TMR_COUNT-1:0] timer_expired; // Condition held past its limit

    // Transmit dominant is low, bus dominant is receiver low
    assign timer_run[TMR_TX] = trx_normal && !BUS_TRANSMIT_IN;
    assign timer_run[TMR_CLAMP] = (trx_normal || trx_rxonly) && !BUS_RX_RAW;
    // Restarts on every entry into wake-capable mode
    assign timer_run[TMR_SILENCE] = trx_wake;

    // One timer per supervised condition
    genvar gi;
    generate
        for (gi = 0; gi < TMR_COUNT; gi++)
        begin : g_timer
            bus_dominance_timer
            #(
                .LIMIT(TIMER_LIMIT[gi])
            )
            u_timer
            (
                .clk(REF_CLK),
                .rst_n(RESET_N),
                .run(timer_run[gi]),
                .expired(timer_expired[gi])
            );
        end
    endgenerate

    // Rearm sources: leaving wake-capable mode, or entering a rearming device mode
    wire trx_left_wake = (prev_trx == TRX_WAKE) && !trx_wake;
    wire dev_entered_rearm = (dev_mode != prev_dev) && dev_rearm_mode;
    wire rearm = trx_left_wake || dev_entered_rearm;

    // A wake counts only while armed in wake-capable mode; further patterns ignored
    wire wake_event = BUS_WAKE_DETECT && trx_wake && !woken;
    // Wake wins over a rearm in the same cycle
    wire next_woken = wake_event || (woken && !rearm);

    // Interrupt only from Normal or Stop; low-power exits stay silent
    wire wake_irq = wake_event && dev_awake;
    wire wake_restart = wake_event && dev_low_power;
    // Watchdog switched on only from Stop and only if software opted in
    wire wake_wd = wake_event && (dev_mode == DEV_STOP) && !WATCHDOG_ENABLED &&
        WATCHDOG_ON_BUS_WAKE;

    // Flags: hardware set beats software clear
    wire next_irq_pending = wake_irq || (!IRQ_OUT_N && !WAKE_STATUS_CLEAR);
    wire next_wake_status = wake_event || (WAKE_SOURCE_STATUS && !WAKE_STATUS_CLEAR);

    // Transmit time-out holds until the input goes recessive or the mode leaves Normal
    wire tx_timeout_rise = timer_expired[TMR_TX] && !tx_blocked;
    wire next_tx_blocked = timer_expired[TMR_TX] ||
        (tx_blocked && !BUS_TRANSMIT_IN && trx_normal);
    wire clamp_rise = timer_expired[TMR_CLAMP] && !clamp_seen;
    wire next_fault = tx_timeout_rise || clamp_rise ||
        (FAULT_FLAG && !FAULT_CLEAR);

    // Undervoltage seen only while the monitor is enabled
    wire uv_now = monitor_en && SUPPLY_UV_IN;
    wire uv_rise = uv_now && !uv_seen;
    wire next_supply_low = uv_rise ||
        (TRANSCEIVER_SUPPLY_LOW_FLAG && !SUPPLY_LOW_CLEAR);

    // Driver active only in Normal, not timed out and with good supply
    wire tx_allowed = trx_normal && !tx_blocked && !uv_now;
    wire next_driver_tx = tx_allowed ? BUS_TRANSMIT_IN : `RESET_DRIVER_TX;

    // Receive output: wake signalling in wake mode, receiver copy in Normal/receive-only
    wire next_receive_out = trx_wake ? !next_woken :
        (monitor_en ? BUS_RX_RAW : `RESET_RECEIVE_OUT);

    // Termination per transceiver mode
    term_e term_wake; // Choice inside wake-capable mode
    term_e term_rx; // Choice inside receive-only mode
    term_e next_term; // Selected termination

    // Unless woken, the bias is left at half supply before silence expires
    assign term_wake = woken ? TERM_FIXED_2V5 :
        (timer_expired[TMR_SILENCE] ? TERM_GND : TERM_HALF);
    assign term_rx = uv_now ? TERM_FIXED_2V5 : TERM_HALF;
    assign next_term = trx_normal ? TERM_HALF :
        trx_rxonly ? term_rx :
        trx_wake ? term_wake : TERM_FLOAT;

    // Event records; buffer back-pressure leaves them accumulated here
    event_s new_events; // Events raised this cycle
    logic push_ready; // Buffer has room
    logic [3:0] fifo_out; // Head of buffer

    assign new_events.wake = wake_event;
    assign new_events.tx_timeout = tx_timeout_rise;
    assign new_events.clamp = clamp_rise;
    assign new_events.supply_low = uv_rise;

    wire push_valid = (pending != '0);
    wire pushed = push_valid && push_ready;
    // New bits are merged in even while a push is under way
    wire [3:0] next_pending = (pushed ? 4'h0 : pending) | new_events;

    // Mode history for rearm detection
    always_ff @(posedge REF_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            prev_dev <= DEV_NORMAL;
            prev_trx <= TRX_OFF;
        end
        else
        begin
            prev_dev <= dev_mode;
            prev_trx <= trx_mode;
        end
    end

    // Wake and interrupt state
    always_ff @(posedge REF_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            woken <= 1'b0;
            IRQ_OUT_N <= `RESET_IRQ_OUT_N;
            WAKE_SOURCE_STATUS <= 1'b0;
        end
        else
        begin
            woken <= next_woken;
            IRQ_OUT_N <= !next_irq_pending;
            WAKE_SOURCE_STATUS <= next_wake_status;
        end
    end

    // Mode requests towards the device-level mode machine; never a Stop-to-Normal move
    always_ff @(posedge REF_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            MODE_RESTART_REQ <= 1'b0;
            WATCHDOG_AUTO_ENABLE <= 1'b0;
        end
        else
        begin
            MODE_RESTART_REQ <= wake_restart;
            WATCHDOG_AUTO_ENABLE <= wake_wd;
        end
    end

    // Fault and supply supervision; mode inputs are never written back
    always_ff @(posedge REF_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            tx_blocked <= 1'b0;
            clamp_seen <= 1'b0;
            uv_seen <= 1'b0;
            FAULT_FLAG <= 1'b0;
            TRANSCEIVER_SUPPLY_LOW_FLAG <= 1'b0;
        end
        else
        begin
            tx_blocked <= next_tx_blocked;
            clamp_seen <= timer_expired[TMR_CLAMP];
            uv_seen <= uv_now;
            FAULT_FLAG <= next_fault;
            TRANSCEIVER_SUPPLY_LOW_FLAG <= next_supply_low;
        end
    end

    // Pin-facing outputs, all registered
    always_ff @(posedge REF_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            DRIVER_TX <= `RESET_DRIVER_TX;
            DRIVER_ENABLE <= 1'b0;
            BUS_RECEIVE_OUT <= `RESET_RECEIVE_OUT;
            TERM_SEL <= TERM_FLOAT;
        end
        else
        begin
            DRIVER_TX <= next_driver_tx;
            DRIVER_ENABLE <= tx_allowed;
            BUS_RECEIVE_OUT <= next_receive_out;
            TERM_SEL <= next_term;
        end
    end

    // Event accumulator in front of the buffer
    always_ff @(posedge REF_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            pending <= '0;
        else
            pending <= next_pending;
    end

    // Event buffer; a stalled reader makes it fill and the accumulator hold
    event_fifo
    #(
        .WIDTH(`EVENT_WIDTH),
        .DEPTH(`EVENT_FIFO_DEPTH)
    )
    u_event_fifo
    (
        .clk(REF_CLK),
        .rst_n(RESET_N),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(pending),
        .out_valid(EVENT_VALID),
        .out_ready(EVENT_READY),
        .out_data(fifo_out)
    );

    assign EVENT_DATA = fifo_out;

endmodule

/* File: rtl/bus_trx_consts.svh */
// Timing, sizing and reset constants of the transceiver supervision block
`ifndef BUS_TRX_CONSTS_SVH
`define BUS_TRX_CONSTS_SVH

// Reference clock rate in MHz (25 ns period)
`define REF_CLK_MHZ 32'd40

// Transmit dominant time-out, least time in microseconds
`define TRANSMIT_DOMINANT_TIMEOUT_US 32'd1000
// Bus clamp time-out, least time in microseconds, kept above the transmit time-out
`define BUS_CLAMP_TIMEOUT_US 32'd2000
// Silence time before ground termination, least time in microseconds
`define SILENCE_TIME_US 32'd1000000

// Cycle counts derived from the times; whole microseconds give whole cycles
`define TRANSMIT_DOMINANT_TIMEOUT_CYCLES_DEF (`TRANSMIT_DOMINANT_TIMEOUT_US * `REF_CLK_MHZ)
`define BUS_CLAMP_TIMEOUT_CYCLES_DEF (`BUS_CLAMP_TIMEOUT_US * `REF_CLK_MHZ)
`define SILENCE_TIME_CYCLES_DEF (`SILENCE_TIME_US * `REF_CLK_MHZ)

// Event buffer geometry
`define EVENT_FIFO_DEPTH 8
`define EVENT_WIDTH 4

// Reset values of the pin-facing outputs
`define RESET_IRQ_OUT_N 1'b1
`define RESET_RECEIVE_OUT 1'b1
`define RESET_DRIVER_TX 1'b1

`endif

/* File: rtl/bus_trx_pkg.sv */
// Types shared by the transceiver supervision block
package bus_trx_pkg;

    // Device mode as reported by the device-level mode machine, Gray along the usual path
    typedef enum logic [2:0]
    {
        DEV_NORMAL = 3'h0,
        DEV_STOP = 3'h1,
        DEV_SLEEP = 3'h3,
        DEV_RESTART = 3'h2,
        DEV_FAILSAFE = 3'h6
    } device_mode_e;

    // Transceiver mode field; the upper bit selects normal or receive-only
    typedef enum logic [1:0]
    {
        TRX_OFF = 2'h0,
        TRX_WAKE = 2'h1,
        TRX_RXONLY = 2'h2,
        TRX_NORMAL = 2'h3
    } trx_mode_e;

    // Bus termination selection towards the analog bias stage
    typedef enum logic [1:0]
    {
        TERM_FLOAT = 2'h0,
        TERM_HALF = 2'h1,
        TERM_FIXED_2V5 = 2'h2,
        TERM_GND = 2'h3
    } term_e;

    // One event record in the event buffer
    typedef struct packed
    {
        logic supply_low;
        logic clamp;
        logic tx_timeout;
        logic wake;
    } event_s;

endpackage

/* File: rtl/event_fifo.sv */
// Synchronous FIFO with valid/ready on both sides
module event_fifo
#(
    parameter int WIDTH = 4,
    parameter int DEPTH = 8
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH]; // Storage words
    logic [AW-1:0] wr_ptr; // Next slot to write
    logic [AW-1:0] rd_ptr; // Oldest slot
    logic [AW:0] fill; // Words held

    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (fill != DEPTH[AW:0]);
    assign out_valid = (fill != '0);
    assign out_data = mem[rd_ptr];

    // Pointer and fill bookkeeping; wrap works since DEPTH is a power of two
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
            if (push && !pop)
                fill <= fill + 1'b1;
            else if (pop && !push)
                fill <= fill - 1'b1;
        end
    end

    // Storage write, no reset needed on data
    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_ptr] <= in_data;
    end

endmodule

/* File: verif/bus_trx_checker.sv */
// Port-level assertions for the transceiver supervision block
module bus_trx_checker
    import bus_trx_pkg::*;
#(
    parameter logic [31:0] TRANSMIT_DOMINANT_TIMEOUT_CYCLES = 32'h14,
    parameter logic [31:0] BUS_CLAMP_TIMEOUT_CYCLES = 32'h28
)
(
    input wire logic REF_CLK,
    input wire logic RESET_N,
    input wire logic [2:0] DEVICE_MODE,
    input wire logic [1:0] TRX_MODE,
    input wire logic WATCHDOG_ENABLED,
    input wire logic WATCHDOG_ON_BUS_WAKE,
    input wire logic BUS_WAKE_DETECT,
    input wire logic BUS_TRANSMIT_IN,
    input wire logic BUS_RX_RAW,
    input wire logic SUPPLY_UV_IN,
    input wire logic IRQ_OUT_N,
    input wire logic BUS_RECEIVE_OUT,
    input wire logic DRIVER_TX,
    input wire logic DRIVER_ENABLE,
    input wire logic [1:0] TERM_SEL,
    input wire logic FAULT_FLAG,
    input wire logic TRANSCEIVER_SUPPLY_LOW_FLAG,
    input wire logic MODE_RESTART_REQ,
    input wire logic WATCHDOG_AUTO_ENABLE
);
    timeunit 1ns;
    timeprecision 1ps;
    // Cycles of unbroken dominance, cheaper than long repetitions
    logic [31:0] tx_run;
    logic [31:0] rx_run;
    wire logic tx_dom = TRX_MODE == TRX_NORMAL && !BUS_TRANSMIT_IN;
    wire logic bus_dom = TRX_MODE[1] && !BUS_RX_RAW;
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RESET_N);
    // Counters restart whenever the dominant run breaks
    always_ff @(posedge REF_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            tx_run <= 32'h0;
            rx_run <= 32'h0;
        end
        else
        begin
            tx_run <= tx_dom ? tx_run + 32'h1 : 32'h0;
            rx_run <= bus_dom ? rx_run + 32'h1 : 32'h0;
        end
    end
    AST_WAKE_RX:
    assert property (BUS_WAKE_DETECT && TRX_MODE == TRX_WAKE && $stable(DEVICE_MODE)
        |=> !BUS_RECEIVE_OUT) else $error("wake left receive high");
    AST_SLEEP_NO_IRQ:
    assert property (BUS_WAKE_DETECT && TRX_MODE == TRX_WAKE && IRQ_OUT_N
        && DEVICE_MODE inside {DEV_SLEEP, DEV_RESTART, DEV_FAILSAFE} |=> IRQ_OUT_N)
        else $error("low power wake raised irq");
    AST_RESTART_SRC:
    assert property (MODE_RESTART_REQ |-> $past(DEVICE_MODE) inside {DEV_SLEEP,
        DEV_RESTART, DEV_FAILSAFE}) else $error("restart asked from normal or stop");
    AST_WD_AUTO:
    assert property (WATCHDOG_AUTO_ENABLE |-> $past(DEVICE_MODE) == DEV_STOP
        && $past(WATCHDOG_ON_BUS_WAKE) && !$past(WATCHDOG_ENABLED))
        else $error("watchdog auto enable without cause");
    AST_TERM_NORMAL:
    assert property (TRX_MODE == TRX_NORMAL |=> TERM_SEL == TERM_HALF)
        else $error("normal mode termination wrong");
    AST_TX_EARLY:
    assert property (tx_run inside {[2 : TRANSMIT_DOMINANT_TIMEOUT_CYCLES - 32'h2]}
        && !SUPPLY_UV_IN && !$past(SUPPLY_UV_IN) |-> !DRIVER_TX)
        else $error("transmit cut before time-out");
    AST_TX_CUT:
    assert property (tx_run >= TRANSMIT_DOMINANT_TIMEOUT_CYCLES + 32'h2
        |-> DRIVER_TX && !DRIVER_ENABLE && FAULT_FLAG) else $error("transmit not cut");
    AST_CLAMP:
    assert property (rx_run == BUS_CLAMP_TIMEOUT_CYCLES + 32'h3 |-> FAULT_FLAG)
        else $error("bus clamp not flagged");
    AST_UV_OFF:
    assert property (TRX_MODE[1] && SUPPLY_UV_IN |=> !DRIVER_ENABLE && DRIVER_TX)
        else $error("driver on during undervoltage");
    AST_UV_GATE:
    assert property ($rose(TRANSCEIVER_SUPPLY_LOW_FLAG)
        |-> $past(TRX_MODE) inside {TRX_RXONLY, TRX_NORMAL}) else $error("uv flag ungated");
    AST_RX_HOLD:
    assert property (!BUS_RECEIVE_OUT && TRX_MODE == TRX_WAKE && $past(TRX_MODE) == TRX_WAKE
        && $past(TRX_MODE, 2) == TRX_WAKE && $stable(DEVICE_MODE)
        && $past(DEVICE_MODE, 2) == DEVICE_MODE |=> !BUS_RECEIVE_OUT)
        else $error("receive released while woken");
endmodule
bind bus_transceiver_wake_supervision bus_trx_checker #(
    .TRANSMIT_DOMINANT_TIMEOUT_CYCLES(TRANSMIT_DOMINANT_TIMEOUT_CYCLES),
    .BUS_CLAMP_TIMEOUT_CYCLES(BUS_CLAMP_TIMEOUT_CYCLES)
) monitor_i (.*);

/* File: verif/ctrl_model.sv */
// Controller model: transmit pin driver and stallable event reader
module ctrl_model
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic dominant, // Ask for a dominant level
    input wire logic stall, // Hold off reading events
    input wire logic ev_valid,
    input wire logic [3:0] ev_data,
    output logic tx, // High is recessive
    output logic ready,
    output logic [3:0] ev_or, // All event bits taken so far
    output int ev_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    // Recessive and not reading until the first edge
    initial
    begin
        tx = 1'b1;
        ready = 1'b0;
    end
    // Pins move just after the edge, like a port driver would
    always @(posedge clk)
    begin
        tx <= #2 !dominant;
        ready <= #2 !stall;
    end
    // Words are taken only on valid and ready together
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ev_or <= 4'h0;
            ev_cnt <= 0;
        end
        else if (ev_valid && ready)
        begin
            ev_or <= ev_or | ev_data;
            ev_cnt <= ev_cnt + 1;
        end
    end
endmodule

/* File: verif/testbench.sv */
// Self-checking bench for the transceiver supervision block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import bus_trx_pkg::*;
    // Short counts keep the run brief
    localparam logic [31:0] TX = 32'h14;
    localparam logic [31:0] CL = 32'h28;
    localparam logic [31:0] SIL = 32'h1e;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    device_mode_e dev = DEV_NORMAL;
    trx_mode_e trx = TRX_OFF;
    logic wd_en = 1'b0, wd_on = 1'b0, wake = 1'b0, rx_raw = 1'b1, uv = 1'b0;
    logic wclr = 1'b0, fclr = 1'b0, sclr = 1'b0, dominant = 1'b0, stall = 1'b0;
    logic tx, ready, irq_n, rx_out, drv_tx, drv_en, wstat, fault, slow, rreq, wdae, ev_valid;
    logic [1:0] term;
    logic [3:0] ev_data, ev_or;
    int ev_cnt, base, n_mismatch = 0, comparisons = 0;
    logic seen_rreq = 1'b0, seen_wdae = 1'b0, low;
    device_mode_e modes[5] = '{DEV_NORMAL, DEV_STOP, DEV_SLEEP, DEV_RESTART, DEV_FAILSAFE};
    bus_transceiver_wake_supervision #(
        .TRANSMIT_DOMINANT_TIMEOUT_CYCLES(TX),
        .BUS_CLAMP_TIMEOUT_CYCLES(CL),
        .SILENCE_TIME_CYCLES(SIL)
    ) bus_transceiver_wake_supervision_i (
        .REF_CLK(clk), .RESET_N(rst_n), .DEVICE_MODE(dev), .TRX_MODE(trx),
        .WATCHDOG_ENABLED(wd_en), .WATCHDOG_ON_BUS_WAKE(wd_on), .BUS_WAKE_DETECT(wake),
        .BUS_TRANSMIT_IN(tx), .BUS_RX_RAW(rx_raw), .SUPPLY_UV_IN(uv),
        .WAKE_STATUS_CLEAR(wclr), .FAULT_CLEAR(fclr), .SUPPLY_LOW_CLEAR(sclr),
        .EVENT_READY(ready), .IRQ_OUT_N(irq_n), .BUS_RECEIVE_OUT(rx_out),
        .DRIVER_TX(drv_tx), .DRIVER_ENABLE(drv_en), .TERM_SEL(term),
        .WAKE_SOURCE_STATUS(wstat), .FAULT_FLAG(fault), .TRANSCEIVER_SUPPLY_LOW_FLAG(slow),
        .MODE_RESTART_REQ(rreq), .WATCHDOG_AUTO_ENABLE(wdae), .EVENT_VALID(ev_valid),
        .EVENT_DATA(ev_data));
    ctrl_model ctrl_model_i (.clk(clk), .rst_n(rst_n), .dominant(dominant), .stall(stall),
        .ev_valid(ev_valid), .ev_data(ev_data), .tx(tx), .ready(ready), .ev_or(ev_or),
        .ev_cnt(ev_cnt));
    // 40 MHz reference clock
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    // One-cycle pulses are caught here so their exact cycle does not matter
    always @(posedge clk)
    begin
        if (rreq)
            seen_rreq = 1'b1;
        if (wdae)
            seen_wdae = 1'b1;
    end
    // Wake interrupt expected only from the awake device modes
    function automatic logic irq_expected(input device_mode_e m);
        return m == DEV_NORMAL || m == DEV_STOP;
    endfunction
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    // Wait n edges, then step off the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic end_sim;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Hang guard, well past the expected run length
    initial
    begin
        #250000;
        n_mismatch++;
        end_sim();
    end
    initial
    begin
        void'($urandom(19));
        cyc(4);
        rst_n = 1'b1;
        chk("reset", 11'h700, {irq_n, rx_out, drv_tx, drv_en, term, wstat, fault, slow,
            ev_valid, rreq});
        // Wake in off mode is ignored
        wake = 1'b1;
        cyc(2);
        wake = 1'b0;
        chk("off_wake", 0, wstat);
        foreach (modes[i])
        begin
            dev = modes[i];
            wd_en = 1'($urandom) && modes[i] != DEV_STOP;
            wd_on = 1'b1;
            trx = TRX_WAKE;
            cyc(3);
            seen_rreq = 1'b0;
            seen_wdae = 1'b0;
            wake = 1'b1;
            cyc(1);
            wake = 1'b0;
            cyc(3);
            low = irq_expected(dev);
            chk("irq_n", !low, irq_n);
            chk("rx_out", 0, rx_out);
            chk("wake_stat", 1, wstat);
            chk("restart_req", !low, seen_rreq);
            chk("wd_auto", dev == DEV_STOP && !wd_en, seen_wdae);
            wclr = 1'b1;
            cyc(1);
            wclr = 1'b0;
            wake = 1'b1;
            cyc(1);
            wake = 1'b0;
            cyc(3);
            chk("irq_rearm", 1, irq_n);
            chk("rx_held", 0, rx_out);
            chk("wake_clr", 0, wstat);
            trx = TRX_OFF;
            cyc(2);
        end
        trx = TRX_NORMAL;
        cyc(3);
        chk("term_normal", TERM_HALF, term);
        trx = TRX_OFF;
        uv = 1'b1;
        cyc(3);
        chk("term_off", TERM_FLOAT, term);
        chk("uv_gated", 0, slow);
        trx = TRX_RXONLY;
        cyc(3);
        chk("term_rx_uv", TERM_FIXED_2V5, term);
        chk("uv_flag_rx", 1, slow);
        // Clear the flag so the Normal-mode check below sees a fresh set
        uv = 1'b0;
        sclr = 1'b1;
        cyc(3);
        sclr = 1'b0;
        chk("term_rx", TERM_HALF, term);
        trx = TRX_NORMAL;
        cyc(3);
        uv = 1'b1;
        cyc(3);
        chk("uv_flag", 1, slow);
        chk("uv_drv", 0, drv_en);
        uv = 1'b0;
        cyc(3);
        chk("uv_back", 1, drv_en);
        sclr = 1'b1;
        // Wake-capable termination: half, ground after silence, 2.5 V once woken
        trx = TRX_WAKE;
        cyc(1);
        sclr = 1'b0;
        cyc(2);
        chk("term_wk", TERM_HALF, term);
        chk("uv_clr", 0, slow);
        cyc(SIL);
        chk("term_gnd", TERM_GND, term);
        wake = 1'b1;
        cyc(1);
        wake = 1'b0;
        cyc(3);
        chk("term_woken", TERM_FIXED_2V5, term);
        trx = TRX_NORMAL;
        cyc(3);
        dominant = 1'b1;
        cyc(TX - 4);
        chk("tx_follow", 0, drv_tx);
        cyc(8);
        chk("tx_cut", 3'h5, {drv_tx, drv_en, fault});
        dominant = 1'b0;
        cyc(4);
        chk("tx_back", 2'h3, {drv_tx, drv_en});
        chk("tx_mode", TERM_HALF, term);
        fclr = 1'b1;
        trx = TRX_RXONLY;
        rx_raw = 1'b0;
        cyc(1);
        fclr = 1'b0;
        cyc(TX + 4);
        chk("clamp_early", 0, fault);
        cyc(CL - TX);
        chk("clamp", 1, fault);
        chk("clamp_term", TERM_HALF, term);
        chk("rx_copy", 0, rx_out);
        rx_raw = 1'b1;
        // Fill the buffer with supply events while the reader stalls
        stall = 1'b1;
        trx = TRX_NORMAL;
        cyc(4);
        base = ev_cnt;
        chk("rx_copy_rec", 1, rx_out);
        repeat (10)
        begin
            uv = 1'b1;
            cyc(2);
            uv = 1'b0;
            cyc(2);
        end
        chk("fifo_full", 1, ev_valid);
        stall = 1'b0;
        cyc(24);
        chk("fifo_words", 1, (ev_cnt - base) inside {[9:10]});
        chk("fifo_empty", 0, ev_valid);
        chk("event_bits", 4'hf, ev_or);
        // Random traffic for the assertions
        repeat (400)
        begin
            dev = modes[$urandom_range(4, 0)];
            trx = trx_mode_e'(2'($urandom));
            rx_raw = 1'($urandom);
            uv = ($urandom % 8) == 0;
            wake = ($urandom % 4) == 0;
            wclr = ($urandom % 8) == 0;
            dominant = 1'($urandom);
            wd_en = 1'($urandom);
            wd_on = 1'($urandom);
            cyc($urandom_range(6, 1));
        end
        end_sim();
    end
endmodule
